// >>> verilog/wbl_pkg.sv
// Constants shared by both ends of the white balance table stage.
// Assumes one 10 MHz clock and the byte-wide register link of wbl_link_if.
package wbl_pkg;
  // ----------------------------------------
  // Device register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h2A;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BANK_MSB = 7;
  localparam int BANK_LSB = 6;
  localparam int EN_BIT = 5;
  localparam int RELOAD_BIT = 4;
  localparam logic [7:0] CTRL_WMASK = 8'hF0;
  localparam int TABLE_DEPTH = 256;
  localparam logic [7:0] LAST_ENTRY = 8'hFF;
  localparam int LOOKUP_LAT = 1;
  typedef enum logic [1:0] {
    BANK_CFG = 2'b00,
    BANK_RED = 2'b01,
    BANK_GRN = 2'b10,
    BANK_BLU = 2'b11
  } wbl_bank_e;
  // ----------------------------------------
  // Host command registers
  // ----------------------------------------
  localparam logic [2:0] H_TADDR = 3'h0;
  localparam logic [2:0] H_WDATA = 3'h1;
  localparam logic [2:0] H_RDGO = 3'h2;
  localparam logic [2:0] H_RDRES = 3'h3;
  localparam logic [2:0] H_CFG = 3'h4;
  localparam logic [2:0] H_STAT = 3'h5;
  localparam int CFG_SIX_BIT = 0;
  localparam int CFG_DITHER = 1;
  localparam logic [7:0] LOW_BITS_MASK = 8'hFC;
endpackage : wbl_pkg

// >>> verilog/wbl_link_if.sv
// Byte-wide register link between the table host and the table stage.
// Assumes both ends share mclk; read data answer one cycle after rd.
`timescale 1ns/10ps
interface wbl_link_if;
  logic [7:0] addr; // Target register or table entry
  logic [7:0] wdata; // Write byte
  logic wr; // One-cycle write strobe
  logic rd; // One-cycle read strobe
  logic [7:0] rdata; // Read byte, cycle after rd
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : wbl_link_if

// >>> verilog/wbl_device.sv
// White balance table stage: three colour tables remapping pixel data.
// Assumes pixels and the register link are synchronous to mclk.
//
// Overview of operation
// R1 - three tables, 256 entries of 8 bits
// R2 - corrected pixel is table entry at value
// R3 - host reads and writes every entry; entry 0x2A is shadowed by the control register
// R4 - control bits 7:6 pick bank
// R5 - addresses 0-255 reach selected colour table; 0x2A reaches the control register instead
// R6 - control bit 5 enables correction
// R7 - control bit 4 permits reloading
// R8 - without reload, refuse data after first load
// R9 - host loads all tables before enabling
// R10 - first load red, green, blue, all entries
// R11 - reload while enabled switches seamlessly
// R12 - unwritten entries keep their values
// R13 - host fills all tables, unused bits zero
// R14 - six-bit entries have low bits zero
// R15 - host enables post_table_dither for 8-bit entries; wbl_host drives it from the CFG_DITHER bit alone, whatever the entry width
// R16 - one-clock latency, syncs delayed alike
// R17 - bank persists, reserved bits read zero
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module wbl_device (
  input wire logic mclk, // 10 MHz clock
  input wire logic rst, // Synchronous reset, high
  wbl_link_if.dev link, // Register link from host
  input wire logic [7:0] pix_r_in, // Red subpixel in
  input wire logic [7:0] pix_g_in, // Green subpixel in
  input wire logic [7:0] pix_b_in, // Blue subpixel in
  input wire logic hs_in, // Horizontal sync in
  input wire logic vs_in, // Vertical sync in
  input wire logic de_in, // Data enable in
  output logic [7:0] pix_r_out, // Red subpixel out
  output logic [7:0] pix_g_out, // Green subpixel out
  output logic [7:0] pix_b_out, // Blue subpixel out
  output logic hs_out, // Horizontal sync out
  output logic vs_out, // Vertical sync out
  output logic de_out, // Data enable out
  output logic load_done // First load complete
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // R1 three table arrays
  logic [7:0] red_table [wbl_pkg::TABLE_DEPTH];
  logic [7:0] green_table [wbl_pkg::TABLE_DEPTH];
  logic [7:0] blue_table [wbl_pkg::TABLE_DEPTH];
  logic [7:0] ctrl_q;
  logic init_done_q;
  logic [7:0] rdata_q;
  wbl_pkg::wbl_bank_e bank;
  logic corr_en;
  logic reload_en;
  logic tbl_wr_ok;
  logic ctrl_hit;
  logic wr_red;
  logic wr_grn;
  logic wr_blu;

  // Field decode of the control register
  // R4 bank select field
  assign bank = wbl_pkg::wbl_bank_e'(ctrl_q[wbl_pkg::BANK_MSB:wbl_pkg::BANK_LSB]);
  assign corr_en = ctrl_q[wbl_pkg::EN_BIT];
  assign reload_en = ctrl_q[wbl_pkg::RELOAD_BIT];
  assign load_done = init_done_q;

  // The control register answers at its address in every bank; otherwise a
  // selected table could never be left again. The cost is that entry 0x2A
  // of each table is shadowed: it is neither written nor read over the link,
  // and a loader must not rely on it.
  // R4 control reachable from every bank
  assign ctrl_hit = (link.addr == wbl_pkg::CTRL_ADDR);

  // Table writes pass only before the first load ends or with reload on
  // R7 reload permission gate
  // R8 refuse after first load
  assign tbl_wr_ok = !ctrl_hit && (!init_done_q || reload_en);

  // R5 entry reach per bank
  assign wr_red = link.wr && tbl_wr_ok && (bank == wbl_pkg::BANK_RED);
  assign wr_grn = link.wr && tbl_wr_ok && (bank == wbl_pkg::BANK_GRN);
  assign wr_blu = link.wr && tbl_wr_ok && (bank == wbl_pkg::BANK_BLU);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Written from any bank; other config offsets are empty
  // R17 reserved bits dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= wbl_pkg::CTRL_RESET;
    end else if (link.wr && ctrl_hit) begin
      // R6 enable bit stored
      ctrl_q <= link.wdata & wbl_pkg::CTRL_WMASK;
    end
  end

  // ----------------------------------------
  // First load tracking
  // ----------------------------------------
  // The load ends with the last blue entry; host order makes blue last
  // R10 blue last entry closes load
  always_ff @(posedge mclk) begin
    if (rst) begin
      init_done_q <= 1'b0;
    end else if (wr_blu && link.addr == wbl_pkg::LAST_ENTRY) begin
      init_done_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Table writes
  // ----------------------------------------
  // Tables have no reset; contents are undefined until loaded.
  // One entry changes per write, so the lookup never sees a torn table.
  // R3 entry write
  // R11 seamless single-entry update
  // R12 other entries untouched
  always_ff @(posedge mclk) begin
    if (wr_red) begin
      red_table[link.addr] <= link.wdata;
    end
  end

  // Green table write port
  always_ff @(posedge mclk) begin
    if (wr_grn) begin
      green_table[link.addr] <= link.wdata;
    end
  end

  // Blue table write port
  always_ff @(posedge mclk) begin
    if (wr_blu) begin
      blue_table[link.addr] <= link.wdata;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Reads are always allowed, even when writes are locked
  // A read answers in the next cycle and holds until the next read
  // R3 entry readback
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (link.rd && ctrl_hit) begin
      // R17 reserved bits are stored as zero
      rdata_q <= ctrl_q;
    end else if (link.rd) begin
      unique case (bank)
        wbl_pkg::BANK_CFG: begin
          // R17 other config addresses read zero
          rdata_q <= 8'h00;
        end
        wbl_pkg::BANK_RED: begin
          rdata_q <= red_table[link.addr];
        end
        wbl_pkg::BANK_GRN: begin
          rdata_q <= green_table[link.addr];
        end
        wbl_pkg::BANK_BLU: begin
          rdata_q <= blue_table[link.addr];
        end
      endcase
    end
  end
  assign link.rdata = rdata_q;

  // ----------------------------------------
  // Pixel path
  // ----------------------------------------
  // Lookup and bypass both take one clock, so toggling the enable
  // never shifts the picture against its syncs.
  // R2 table lookup
  // R6 bypass when disabled
  // R16 one-clock data latency
  always_ff @(posedge mclk) begin
    if (rst) begin
      pix_r_out <= 8'h00;
      pix_g_out <= 8'h00;
      pix_b_out <= 8'h00;
    end else if (corr_en) begin
      pix_r_out <= red_table[pix_r_in];
      pix_g_out <= green_table[pix_g_in];
      pix_b_out <= blue_table[pix_b_in];
    end else begin
      pix_r_out <= pix_r_in;
      pix_g_out <= pix_g_in;
      pix_b_out <= pix_b_in;
    end
  end

  // Syncs follow the data by the same single stage
  // R16 sync alignment
  always_ff @(posedge mclk) begin
    if (rst) begin
      hs_out <= 1'b0;
      vs_out <= 1'b0;
      de_out <= 1'b0;
    end else begin
      hs_out <= hs_in;
      vs_out <= vs_in;
      de_out <= de_in;
    end
  end
endmodule : wbl_device

// >>> verilog/wbl_host.sv
// Host end: turns software register accesses into link transfers.
// Assumes software on a plain strobe port, data one cycle after read.
`timescale 1ns/10ps
module wbl_host (
  input wire logic mclk, // 10 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [2:0] sw_addr, // Command register select
  input wire logic [7:0] sw_wdata, // Command write data
  input wire logic sw_wr, // Write strobe
  input wire logic sw_rd, // Read strobe
  output logic [7:0] sw_rdata, // Read data, cycle after strobe
  output logic post_table_dither, // Dither stage enable
  wbl_link_if.host link // Link to table stage
);
  logic [7:0] taddr_q;
  logic [7:0] wdata_q;
  logic wr_q;
  logic rd_q;
  logic rd_pend_q;
  logic [7:0] rdres_q;
  logic [1:0] cfg_q;
  logic [1:0] bank_q;
  logic [2:0] loaded_q;
  logic [7:0] out_byte;
  logic all_loaded;
  logic [7:0] sw_rdata_q;

  assign all_loaded = &loaded_q;
  assign post_table_dither = cfg_q[wbl_pkg::CFG_DITHER];
  assign link.addr = taddr_q;
  assign link.wdata = wdata_q;
  assign link.wr = wr_q;
  assign link.rd = rd_q;
  assign sw_rdata = sw_rdata_q;

  // Outgoing byte shaped before it is sent
  always_comb begin
    out_byte = sw_wdata;
    if (taddr_q == wbl_pkg::CTRL_ADDR && !all_loaded) begin
      // R9 no enable before load
      out_byte[wbl_pkg::EN_BIT] = 1'b0;
    end else if (taddr_q != wbl_pkg::CTRL_ADDR && bank_q != 2'b00 && cfg_q[wbl_pkg::CFG_SIX_BIT]) begin
      // R13 unused bits zero
      // R14 six-bit low bits cleared
      out_byte = sw_wdata & wbl_pkg::LOW_BITS_MASK;
    end
  end

  // ----------------------------------------
  // Software command registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      taddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cfg_q <= 2'b00;
    end else begin
      wr_q <= sw_wr && sw_addr == wbl_pkg::H_WDATA;
      rd_q <= sw_wr && sw_addr == wbl_pkg::H_RDGO;
      if (sw_wr && sw_addr == wbl_pkg::H_TADDR) begin
        taddr_q <= sw_wdata;
      end
      if (sw_wr && sw_addr == wbl_pkg::H_WDATA) begin
        wdata_q <= out_byte;
      end
      // R15 dither enable output
      if (sw_wr && sw_addr == wbl_pkg::H_CFG) begin
        cfg_q <= sw_wdata[1:0];
      end
    end
  end

  // Mirror of the bank field and first-load progress
  // The control address reaches the device in every bank
  // R10 ordered load tracking
  always_ff @(posedge mclk) begin
    if (rst) begin
      bank_q <= 2'b00;
      loaded_q <= 3'b000;
    end else if (wr_q) begin
      if (taddr_q == wbl_pkg::CTRL_ADDR) begin
        bank_q <= wdata_q[wbl_pkg::BANK_MSB:wbl_pkg::BANK_LSB];
      end else if (bank_q != 2'b00 && taddr_q == wbl_pkg::LAST_ENTRY) begin
        if (bank_q == 2'b01 || loaded_q[bank_q - 2'b10]) begin
          loaded_q[bank_q - 2'b01] <= 1'b1;
        end
      end
    end
  end

  // Capture of link read answers
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      rdres_q <= 8'h00;
    end else begin
      rd_pend_q <= rd_q;
      if (rd_pend_q) begin
        rdres_q <= link.rdata;
      end
    end
  end

  // Software read mux
  always_ff @(posedge mclk) begin
    if (rst) begin
      sw_rdata_q <= 8'h00;
    end else if (sw_rd) begin
      unique case (sw_addr)
        wbl_pkg::H_TADDR: sw_rdata_q <= taddr_q;
        wbl_pkg::H_WDATA: sw_rdata_q <= wdata_q;
        wbl_pkg::H_RDRES: sw_rdata_q <= rdres_q;
        wbl_pkg::H_CFG: sw_rdata_q <= {6'h00, cfg_q};
        wbl_pkg::H_STAT: sw_rdata_q <= {3'h0, rd_q | rd_pend_q, bank_q, loaded_q[1:0] == 2'b11, all_loaded};
        default: sw_rdata_q <= 8'h00;
      endcase
    end else begin
      sw_rdata_q <= 8'h00;
    end
  end
endmodule : wbl_host

// >>> test/wbl_checker.sv
// Link checker for the white balance table stage.
// Assumes it sits beside the link interface, everything on mclk.
`timescale 1ns/10ps
module wbl_checker (
  input wire logic mclk, // Clock
  input wire logic rst, // Sync reset
  input wire logic [7:0] addr, // Link address
  input wire logic [7:0] wdata, // Link write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [7:0] rdata // Read data
);
  // ------------------------------
  // Shadow of device state
  // ------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] tbl_q [0:1023];
  logic [1023:0] known_q;
  logic [1:0] prog_q;
  logic [7:0] look_q;
  logic tw;
  logic ok;
  logic [9:0] idx;
  assign idx = {ctrl_q[7:6], addr};
  assign tw = wr && addr != wbl_pkg::CTRL_ADDR && ctrl_q[7:6] != 2'h0;
  // writes pass only before load end or with reload set
  assign ok = tw && (prog_q != 2'h3 || ctrl_q[wbl_pkg::RELOAD_BIT]);
  // Control shadow keeps only the upper nibble
  always_ff @(posedge mclk) begin
    if (rst) ctrl_q <= 8'h00;
    else if (wr && addr == wbl_pkg::CTRL_ADDR) ctrl_q <= wdata & wbl_pkg::CTRL_WMASK;
  end
  // Tables are not reset, so only entries seen written are compared
  always_ff @(posedge mclk) begin
    if (ok) tbl_q[idx] <= wdata;
    look_q <= tbl_q[idx];
  end
  always_ff @(posedge mclk) begin
    if (rst) known_q <= '0;
    else if (ok) known_q[idx] <= 1'b1;
  end
  // Load progress: last entry of the next table in line
  always_ff @(posedge mclk) begin
    if (rst) prog_q <= 2'h0;
    else if (tw && addr == wbl_pkg::LAST_ENTRY && ctrl_q[7:6] == prog_q + 2'h1) prog_q <= prog_q + 2'h1;
  end
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_bank_readback: assert property (rd && addr == wbl_pkg::CTRL_ADDR |=> rdata[7:6] == ctrl_q[7:6])
    else $error("bank field read back wrong");
  a_ctrl_flags: assert property (rd && addr == wbl_pkg::CTRL_ADDR |=> rdata[5:4] == ctrl_q[5:4])
    else $error("control flags read back wrong");
  a_reserved_zero: assert property (rd && addr == wbl_pkg::CTRL_ADDR |=> rdata[3:0] == 4'h0)
    else $error("reserved bits not zero");
  a_cfg_zero: assert property (rd && ctrl_q[7:6] == 2'h0 && addr != wbl_pkg::CTRL_ADDR |=> rdata == 8'h00)
    else $error("unused config address not zero");
  a_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  a_table_readback: assert property (rd && tw == 1'b0 && ctrl_q[7:6] != 2'h0 && addr != wbl_pkg::CTRL_ADDR
    && known_q[idx] |=> rdata == look_q)
    else $error("table entry read back wrong");
  a_en_loaded: assert property (wr && addr == wbl_pkg::CTRL_ADDR && wdata[wbl_pkg::EN_BIT] |-> prog_q == 2'h3)
    else $error("correction enabled before load");
  a_strobe_excl: assert property (wr |-> !rd)
    else $error("write and read strobes together");
endmodule : wbl_checker

// >>> test/test_white_balance_lut.sv
// Testbench for both ends of the white balance table stage.
// Assumes software drives the host end, which drives the link.
`timescale 1ns/10ps
module test_white_balance_lut;
  localparam logic [7:0] CA = wbl_pkg::CTRL_ADDR;
  logic mclk = 1'b0, rst = 1'b1, sw_wr = 1'b0, sw_rd = 1'b0, hs_in = 1'b0, vs_in = 1'b0, de_in = 1'b0;
  logic ptd, load_done, hs_out, vs_out, de_out;
  logic en = 1'b0, act = 1'b0, act_d = 1'b0, rd_p = 1'b0;
  logic [2:0] sw_addr = 3'h0;
  logic [7:0] sw_wdata = 8'h00, pr = 8'h00, pg = 8'h00, pb = 8'h00;
  logic [7:0] sw_rdata, qr, qg, qb;
  logic [7:0] tbl [1:3][0:255];
  logic [26:0] pq [$];
  logic [7:0] rq [$];
  integer seed = 38;
  int err_total = 0;
  int num_checks = 0;
  wbl_link_if u_wbl_link_if ();
  wbl_host u_wbl_host (.mclk(mclk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .post_table_dither(ptd), .link(u_wbl_link_if));
  wbl_device u_wbl_device (.mclk(mclk), .rst(rst), .link(u_wbl_link_if), .pix_r_in(pr), .pix_g_in(pg),
    .pix_b_in(pb), .hs_in(hs_in), .vs_in(vs_in), .de_in(de_in), .pix_r_out(qr), .pix_g_out(qg),
    .pix_b_out(qb), .hs_out(hs_out), .vs_out(vs_out), .de_out(de_out), .load_done(load_done));
  wbl_checker u_wbl_checker (.mclk(mclk), .rst(rst), .addr(u_wbl_link_if.addr), .wdata(u_wbl_link_if.wdata),
    .wr(u_wbl_link_if.wr), .rd(u_wbl_link_if.rd), .rdata(u_wbl_link_if.rdata));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(input string nm, input logic [26:0] seen, input logic [26:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // One strobe then an idle cycle, so a strobe is never set twice at once
  task automatic sw_op(input logic w, input logic [2:0] a, input logic [7:0] d);
    if (!w) rq.push_back(d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= w;
    sw_rd <= !w;
    @(posedge mclk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    @(posedge mclk);
  endtask : sw_op
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    sw_op(1'b1, wbl_pkg::H_TADDR, a);
    sw_op(1'b1, wbl_pkg::H_WDATA, d);
  endtask : dev_wr
  task automatic dev_rd(input logic [7:0] a, input logic [7:0] e);
    sw_op(1'b1, wbl_pkg::H_TADDR, a);
    sw_op(1'b1, wbl_pkg::H_RDGO, 8'h00);
    repeat (3) @(posedge mclk);
    sw_op(1'b0, wbl_pkg::H_RDRES, e);
  endtask : dev_rd
  // Entry 42 shares the control address, so it is never used
  function automatic logic [7:0] pick();
    logic [7:0] v;
    v = $random(seed);
    return (v == 8'h2A) ? 8'h2B : v;
  endfunction : pick
  function automatic logic [7:0] fx(input int c, input logic [7:0] v);
    return en ? tbl[c][v] : v;
  endfunction : fx
  task automatic run_pix(input int n);
    logic [7:0] r, g, b;
    logic [2:0] s;
    @(posedge mclk);
    repeat (n) begin
      r = pick();
      g = pick();
      b = pick();
      s = $random(seed);
      {pr, pg, pb, hs_in, vs_in, de_in} <= {r, g, b, s};
      act <= 1'b1;
      pq.push_back({fx(1, r), fx(2, g), fx(3, b), s});
      @(posedge mclk);
    end
    act <= 1'b0;
    @(posedge mclk);
  endtask : run_pix
  // Watcher: outputs settle mid-cycle, one cycle after the cause
  always @(negedge mclk) begin
    if (act_d) check("pixel", {qr, qg, qb, hs_out, vs_out, de_out}, pq.pop_front());
    act_d = act;
    if (rd_p) check("read", {19'h0, sw_rdata}, {19'h0, rq.pop_front()});
    rd_p = sw_rd;
  end
  initial begin
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    complete_run();
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    logic [7:0] a;
    logic [1:0] c;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    dev_rd(CA, 8'h00);
    dev_wr(CA, 8'h2F);
    dev_rd(CA, 8'h00);
    dev_wr(8'h10, 8'h55);
    dev_rd(8'h10, 8'h00);
    sw_op(1'b0, 3'h7, 8'h00);
    for (int k = 1; k < 4; k++) begin
      c = k[1:0];
      dev_wr(CA, {c, 6'h00});
      dev_rd(CA, {c, 6'h00});
      for (int i = 0; i < 256; i++) begin
        tbl[k][i] = pick();
        if (i != 42) dev_wr(i[7:0], tbl[k][i]);
      end
    end
    // Last write lands at the edge that ended dev_wr; let it settle
    @(posedge mclk);
    check("load_done", {26'h0, load_done}, 27'h1);
    sw_op(1'b0, wbl_pkg::H_STAT, 8'h0F);
    for (int k = 0; k < 6; k++) begin
      a = pick();
      c = 2'(1 + k % 3);
      dev_wr(CA, {c, 6'h00});
      dev_rd(a, tbl[c][a]);
    end
    dev_wr(CA, 8'h00);
    run_pix(20);
    dev_wr(CA, 8'h20);
    en = 1'b1;
    run_pix(40);
    dev_wr(CA, 8'h60);
    dev_wr(8'h05, ~tbl[1][5]);
    dev_rd(8'h05, tbl[1][5]);
    dev_wr(CA, 8'h70);
    tbl[1][5] = ~tbl[1][5];
    dev_wr(8'h05, tbl[1][5]);
    dev_rd(8'h05, tbl[1][5]);
    dev_rd(8'h06, tbl[1][6]);
    sw_op(1'b1, wbl_pkg::H_CFG, 8'h03);
    check("dither", {26'h0, ptd}, 27'h1);
    sw_op(1'b0, wbl_pkg::H_CFG, 8'h03);
    dev_wr(CA, 8'hB0);
    dev_wr(8'h07, 8'hFF);
    tbl[2][7] = 8'hFF & wbl_pkg::LOW_BITS_MASK;
    dev_rd(8'h07, tbl[2][7]);
    dev_wr(CA, 8'h30);
    run_pix(40);
    complete_run();
  end
endmodule : test_white_balance_lut
